// file: sim/sac_analog_model.sv
// Behavioural analog core: mux, DAC and comparator beside the converter control.
// Assumes channel levels arrive from the bench as 8-bit codes, channel i in byte i.
`timescale 1ns/1ps
module sac_analog_model (
  // Clock
  input wire logic clk,
  // From the control block
  input wire logic [7:0] dac_code,
  input wire logic [4:0] mux_select,
  input wire logic analog_power_down,
  // Bench levels
  input wire logic [31:0] ext_level,
  // To the control block
  output logic comp_high
);
  // ==========================================================================
  // Input selection
  logic [7:0] vin;
  logic valid;
  logic noise = 1'b0;

  always_comb begin
    valid = 1'b1;
    vin = 8'h00;
    case (mux_select)
      5'h00: vin = ext_level[7:0];
      5'h01: vin = ext_level[15:8];
      5'h02: vin = ext_level[23:16];
      5'h03: vin = ext_level[31:24];
      sac_pkg::CHAN_VREF_HI: vin = 8'hff;
      sac_pkg::CHAN_VREF_LO: vin = 8'h00;
      default: valid = 1'b0;
    endcase
  end

  // Changing pattern, so a dead core never looks like a steady level
  always_ff @(posedge clk) begin
    noise <= ~noise;
  end

  // ideal compare, garbage when unused or off
  assign comp_high = (valid && !analog_power_down) ? (vin >= dac_code) : noise;
endmodule // sac_analog_model

// file: sim/sac_control_tb_top.sv
// Self-checking bench for the converter control block and its analog model.
// Assumes a 50 MHz bus clock and the register map of the package.
`timescale 1ns/1ps
module sac_control_tb_top;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic comp_high;
  logic [7:0] dac_code;
  logic [4:0] mux_select;
  logic analog_power_down;
  sac_pkg::sac_port_t port_a = '0;
  logic [5:0] pin_force_input;
  logic [5:0] port_dir_eff;
  logic [5:0] port_read;
  logic conv_irq;
  logic [31:0] ext_level = 32'h5afe_017f;
  int error_cnt = 0;
  int num_checks = 0;

  // Bus clock, 20 ns period
  initial begin
    forever #10 clk = ~clk;
  end

  sac_control dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .comp_high(comp_high), .dac_code(dac_code), .mux_select(mux_select),
    .analog_power_down(analog_power_down), .port_a(port_a), .pin_force_input(pin_force_input),
    .port_dir_eff(port_dir_eff), .port_read(port_read), .conv_irq(conv_irq));

  sac_analog_model core (.clk(clk), .dac_code(dac_code), .mux_select(mux_select),
    .analog_power_down(analog_power_down), .ext_level(ext_level), .comp_high(comp_high));

  // ==========================================================================
  // Shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Counts edges from the write edge until the request shows
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400) begin
        error_cnt++;
        $display("CHECK FAILED irq wait expected rise seen none");
        close_out();
      end
    end while (conv_irq !== 1'b1);
  endtask

  task automatic run_conv(input logic [7:0] ctrl, input int n_exp, input logic [7:0] v_exp);
    int n;
    logic [7:0] d;
    wr(sac_pkg::ADDR_SC, ctrl);
    wait_irq(n);
    check("conversion cycles", n_exp[15:0], n[15:0]);
    rd(sac_pkg::ADDR_RESULT, d);
    check("result", {8'h00, v_exp}, {8'h00, d});
    check("irq after result read", 16'h0000, {15'h0000, conv_irq});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    rd(sac_pkg::ADDR_SC, d);
    check("control reset", 16'h001f, {8'h00, d});
    rd(sac_pkg::ADDR_CLK, d);
    check("divider reset", 16'h0000, {8'h00, d});
    rd(sac_pkg::ADDR_RESULT, d);
    check("result reset", 16'h0000, {8'h00, d});
    rd(8'h40, d);
    check("unmapped read", 16'h0000, {8'h00, d});
    check("power down at reset", 16'h0001, {15'h0000, analog_power_down});
    $display("test reset done");
  endtask

  // Divide codes 0 to 4 and 7, then a control write in mid-conversion
  task automatic t_divider();
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int ratio [6] = '{1, 2, 4, 8, 16, 16};
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      wr(sac_pkg::ADDR_CLK, {codes[i], 5'h00});
      rd(sac_pkg::ADDR_CLK, d);
      check("divider readback", {8'h00, codes[i], 5'h00}, {8'h00, d});
      run_conv(8'h40, 16 * ratio[i], ext_level[7:0]);
    end
    wr(sac_pkg::ADDR_CLK, 8'h20);
    wr(sac_pkg::ADDR_SC, 8'h41);
    repeat (10) @(posedge clk);
    run_conv(8'h41, 32, ext_level[15:8]);
    wr(sac_pkg::ADDR_CLK, 8'h00);
    $display("test divider done");
  endtask

  task automatic t_flag();
    logic [7:0] d;
    wr(sac_pkg::ADDR_SC, 8'h01);
    repeat (20) @(posedge clk);
    rd(sac_pkg::ADDR_SC, d);
    check("flag set", 16'h0081, {8'h00, d});
    check("no irq without enable", 16'h0000, {15'h0000, conv_irq});
    rd(sac_pkg::ADDR_RESULT, d);
    check("single result", {8'h00, ext_level[15:8]}, {8'h00, d});
    rd(sac_pkg::ADDR_SC, d);
    check("flag cleared", 16'h0001, {8'h00, d});
    repeat (40) @(posedge clk);
    rd(sac_pkg::ADDR_SC, d);
    check("single stays idle", 16'h0001, {8'h00, d});
    $display("test flag done");
  endtask

  // Result overwritten while never read
  task automatic t_cont();
    logic [7:0] d;
    wr(sac_pkg::ADDR_SC, 8'h23);
    repeat (40) @(posedge clk);
    rd(sac_pkg::ADDR_SC, d);
    check("continuous flag", 16'h00a3, {8'h00, d});
    ext_level[31:24] <= 8'ha5;
    repeat (40) @(posedge clk);
    rd(sac_pkg::ADDR_RESULT, d);
    check("overwritten result", 16'h00a5, {8'h00, d});
    wr(sac_pkg::ADDR_SC, 8'h1f);
    $display("test continuous done");
  endtask

  task automatic t_irq();
    int n;
    logic [7:0] d;
    wr(sac_pkg::ADDR_SC, 8'h42);
    wait_irq(n);
    rd(sac_pkg::ADDR_SC, d);
    check("flag hidden with enable", 16'h0042, {8'h00, d});
    wr(sac_pkg::ADDR_SC, 8'h5f);
    wait_mode <= 1'b1;
    #1;
    check("irq dropped by write", 16'h0000, {15'h0000, conv_irq});
    repeat (300) @(posedge clk);
    #1;
    check("off code converts nothing", 16'h0000, {15'h0000, conv_irq});
    check("off code powers down", 16'h0001, {15'h0000, analog_power_down});
    $display("test irq done");
  endtask

  // References converted while the core sits in wait mode
  task automatic t_refs();
    @(posedge clk);
    wait_mode <= 1'b1;
    run_conv(8'h5d, 16, 8'hff);
    run_conv(8'h5e, 16, 8'h00);
    @(posedge clk);
    wait_mode <= 1'b0;
    $display("test refs done");
  endtask

  task automatic t_stop();
    int n;
    logic [7:0] d;
    wr(sac_pkg::ADDR_SC, 8'h40);
    repeat (8) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (30) @(posedge clk);
    #1;
    check("no completion in stop", 16'h0000, {15'h0000, conv_irq});
    check("inactive in stop", 16'h0001, {15'h0000, analog_power_down});
    @(posedge clk);
    stop_mode <= 1'b0;
    wait_irq(n);
    check("resume window", 16'h0001, {15'h0000, (n >= 16 && n <= 18)});
    rd(sac_pkg::ADDR_RESULT, d);
    check("result after stop", {8'h00, ext_level[7:0]}, {8'h00, d});
    run_conv(8'h40, 16, ext_level[7:0]);
    $display("test stop done");
  endtask

  // Pins 0,1 have direction 1, pins 4,5 direction 0 and a high pin level
  task automatic t_port();
    logic [5:0] m [4] = '{6'h01, 6'h02, 6'h10, 6'h20};
    @(posedge clk);
    port_a <= '{latch: 6'h2a, ddr: 6'h0f, pin: 6'h35};
    for (int k = 0; k < 4; k++) begin
      wr(sac_pkg::ADDR_SC, {3'h0, k[4:0]});
      repeat (3) @(posedge clk);
      #1;
      check("forced input", {10'h000, m[k]}, {10'h000, pin_force_input});
      check("direction", {10'h000, 6'h0f & ~m[k]}, {10'h000, port_dir_eff});
      check("port read", {10'h000, 6'h0a | (6'h30 & 6'h35 & ~m[k])}, {10'h000, port_read});
    end
    wr(sac_pkg::ADDR_SC, 8'h1f);
    $display("test port done");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_divider();
    t_flag();
    t_cont();
    t_irq();
    t_refs();
    t_stop();
    t_port();
    close_out();
  end

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("CHECK FAILED run length expected finish seen timeout");
    close_out();
  end
endmodule // sac_control_tb_top

// file: verilog/sac_control.sv
// Control logic of an 8-bit, four-channel successive-approximation converter.
// Assumes a byte register port on the bus clock, an outside DAC and comparator,
// and port A logic that applies the override and read masks given here.
`timescale 1ns/1ps
module sac_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Low-power modes
  input wire logic wait_mode,
  input wire logic stop_mode,
  // Analog core
  input wire logic comp_high,
  output logic [7:0] dac_code,
  output logic [4:0] mux_select,
  output logic analog_power_down,
  // Port A override
  input wire sac_pkg::sac_port_t port_a,
  output logic [5:0] pin_force_input,
  output logic [5:0] port_dir_eff,
  output logic [5:0] port_read,
  // Interrupt request
  output logic conv_irq
);

  // ==========================================================================
  // Declarations
  sac_pkg::sac_sc_t conv_status_control;
  logic [2:0] prescaler_field;
  logic [7:0] adc_result;
  sac_pkg::sac_state_t state;
  logic sc_wr;
  logic res_rd;
  logic clk_wr;
  logic restart;
  logic tick;
  logic step;
  logic done;
  logic [3:0] phase;
  logic [7:0] sar_trial;
  logic [7:0] sar_result;
  logic powered_off;
  logic [5:0] sel_mask;
  logic [7:0] next_rdata;
  logic [4:0] tick_count;

  // ==========================================================================
  // Register decode
  assign sc_wr = reg_wr && (reg_addr == sac_pkg::ADDR_SC);
  assign clk_wr = reg_wr && (reg_addr == sac_pkg::ADDR_CLK);
  assign res_rd = reg_rd && (reg_addr == sac_pkg::ADDR_RESULT);
  assign powered_off = (conv_status_control.channel_field == sac_pkg::CHAN_OFF);

  // restart on control write
  // Stop also holds both counters so a resumed conversion starts clean
  assign restart = sc_wr || stop_mode;

  // wait mode does not gate stepping
  assign step = tick && (state == sac_pkg::SAC_CONV) && !stop_mode && !powered_off;

  // ==========================================================================
  // Submodules
  sac_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .restart(restart),
    .div_sel(prescaler_field),
    .tick(tick)
  );

  sac_sar u_sar (
    .clk(clk),
    .rst(rst),
    .start(restart),
    .step(step),
    .comp_high(comp_high),
    .trial(sar_trial),
    .phase(phase),
    .done(done),
    .result(sar_result)
  );

  // ==========================================================================
  // Control register and completion flag
  // One process owns the whole register image, so the flag and the
  // written fields never end up with two drivers
  // reset values
  // flag set beats the read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_status_control <= sac_pkg::SC_RESET;
    end else begin
      if (sc_wr) begin
        conv_status_control.ien <= reg_wdata[sac_pkg::SC_IEN_BIT];
        conv_status_control.cont <= reg_wdata[sac_pkg::SC_CONT_BIT];
        conv_status_control.channel_field <= reg_wdata[4:0];
      end
      if (done && !conv_status_control.ien) begin
        conv_status_control.complete_flag <= 1'b1;
      end else if (res_rd || (sc_wr && reg_wdata[sac_pkg::SC_IEN_BIT])) begin
        conv_status_control.complete_flag <= 1'b0;
      end
    end
  end

  // Clock select register
  always_ff @(posedge clk) begin
    if (rst) begin
      prescaler_field <= sac_pkg::DIV_RESET;
    end else if (clk_wr) begin
      prescaler_field <= reg_wdata[sac_pkg::CLK_DIV_LSB +: 3];
    end
  end

  // ==========================================================================
  // Sequencer
  // arm on control write
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sac_pkg::SAC_IDLE;
    end else if (sc_wr) begin
      state <= (reg_wdata[4:0] == sac_pkg::CHAN_OFF) ? sac_pkg::SAC_IDLE : sac_pkg::SAC_CONV;
    end else if (done && !conv_status_control.cont) begin
      state <= sac_pkg::SAC_IDLE;
    end
  end

  // unused codes still convert, value meaningless
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_result <= 8'h00;
    end else if (done) begin
      adc_result <= sar_result;
    end
  end

  // ==========================================================================
  // Interrupt request
  // request set and drop
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_irq <= 1'b0;
    end else if (done && conv_status_control.ien) begin
      conv_irq <= 1'b1;
    end else if (res_rd || sc_wr) begin
      conv_irq <= 1'b0;
    end
  end

  // ==========================================================================
  // Read path
  // flag masked under interrupt mode
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        sac_pkg::ADDR_SC: begin
          next_rdata = {conv_status_control.complete_flag && !conv_status_control.ien,
                        conv_status_control.ien, conv_status_control.cont, conv_status_control.channel_field};
        end
        sac_pkg::ADDR_RESULT: begin
          next_rdata = adc_result;
        end
        sac_pkg::ADDR_CLK: begin
          next_rdata = {prescaler_field, 5'h00};
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Analog side
  // channel code passed to mux
  always_ff @(posedge clk) begin
    if (rst) begin
      mux_select <= sac_pkg::CHAN_OFF;
      analog_power_down <= 1'b1;
      dac_code <= sac_pkg::SAR_FIRST_TRIAL;
    end else begin
      mux_select <= conv_status_control.channel_field;
      analog_power_down <= powered_off || stop_mode;
      dac_code <= sar_trial;
    end
  end

  // ==========================================================================
  // Port A override
  // external channel to pin map
  assign sel_mask = sac_pkg::chan_mask(conv_status_control.channel_field);

  // selected pin read value
  // Registered so the port sees a glitch-free override, at one cycle of lag
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_force_input <= 6'h00;
      port_dir_eff <= 6'h00;
      port_read <= 6'h00;
    end else begin
      pin_force_input <= sel_mask;
      port_dir_eff <= port_a.ddr & ~sel_mask;
      port_read <= (sel_mask & port_a.ddr & port_a.latch)
                 | (~sel_mask & ((port_a.ddr & port_a.latch) | (~port_a.ddr & port_a.pin)));
    end
  end

  // ==========================================================================
  // Checks
  // Divided clocks seen since the conversion started
  always_ff @(posedge clk) begin
    if (rst || restart || done) begin
      tick_count <= 5'h00;
    end else if (step) begin
      tick_count <= tick_count + 5'h01;
    end
  end

  sequence conv_done_s;
    done ##0 conv_status_control.ien == 1'b0;
  endsequence

  sequence flag_up_s;
    ##1 conv_status_control.complete_flag;
  endsequence

  sixteen_ticks_a: assert property (@(posedge clk) disable iff (rst)
    done |-> tick_count == 5'(sac_pkg::CONV_CYCLES - 1))
    else $error("conversion not sixteen clocks long");

  write_arms_a: assert property (@(posedge clk) disable iff (rst)
    sc_wr && reg_wdata[4:0] != sac_pkg::CHAN_OFF |=> state == sac_pkg::SAC_CONV && phase == 4'h0)
    else $error("control write did not arm a fresh conversion");

  continuous_rearm_a: assert property (@(posedge clk) disable iff (rst)
    done && conv_status_control.cont && !sc_wr |=> state == sac_pkg::SAC_CONV)
    else $error("continuous mode stopped");

  single_idle_a: assert property (@(posedge clk) disable iff (rst)
    done && !conv_status_control.cont && !sc_wr |=> state == sac_pkg::SAC_IDLE)
    else $error("single conversion did not return idle");

  flag_set_a: assert property (@(posedge clk) disable iff (rst)
    conv_done_s |-> flag_up_s)
    else $error("complete flag not set");

  flag_hidden_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == sac_pkg::ADDR_SC && conv_status_control.ien |=> !reg_rdata[sac_pkg::SC_FLAG_BIT])
    else $error("complete flag visible in interrupt mode");

  irq_raise_drop_a: assert property (@(posedge clk) disable iff (rst)
    (done && conv_status_control.ien |=> conv_irq) and (res_rd && !done |=> !conv_irq))
    else $error("interrupt request wrong");

  reset_values_a: assert property (@(posedge clk)
    rst |=> conv_status_control.channel_field == sac_pkg::CHAN_OFF && !conv_status_control.ien
      && !conv_status_control.cont && !conv_status_control.complete_flag)
    else $error("control register reset value wrong");

  off_no_step_a: assert property (@(posedge clk) disable iff (rst)
    powered_off |-> !step ##1 analog_power_down)
    else $error("conversion while powered off");

  pin_override_a: assert property (@(posedge clk) disable iff (rst)
    ##1 (pin_force_input & port_dir_eff) == 6'h00)
    else $error("selected pin left as output");

  stop_abort_a: assert property (@(posedge clk) disable iff (rst)
    stop_mode |-> !step ##1 phase == 4'h0)
    else $error("conversion ran in stop mode");

  wait_runs_a: assert property (@(posedge clk) disable iff (rst)
    wait_mode && tick && state == sac_pkg::SAC_CONV && !stop_mode && !powered_off |-> step)
    else $error("conversion stalled in wait mode");

  result_update_a: assert property (@(posedge clk) disable iff (rst)
    done |=> adc_result == $past(sar_result))
    else $error("result register not refreshed");

  restart_counters_a: assert property (@(posedge clk) disable iff (rst)
    sc_wr |=> phase == 4'h0 && tick_count == 5'h00)
    else $error("control write did not restart counters");

endmodule // sac_control

// file: verilog/sac_pkg.sv
// Shared constants and types for the successive-approximation converter control.
// Assumes an 8-bit register port on the bus clock and an analog core outside.
package sac_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_SC = 8'h3c;
  localparam logic [7:0] ADDR_RESULT = 8'h3d;
  localparam logic [7:0] ADDR_CLK = 8'h3e;

  // ==========================================================================
  // Field positions
  localparam int SC_FLAG_BIT = 7;
  localparam int SC_IEN_BIT = 6;
  localparam int SC_CONT_BIT = 5;
  localparam int CLK_DIV_LSB = 5;

  // ==========================================================================
  // Channel codes
  localparam logic [4:0] CHAN_EXT_LAST = 5'h03;
  localparam logic [4:0] CHAN_RESERVED = 5'h1b;
  localparam logic [4:0] CHAN_VREF_HI = 5'h1d;
  localparam logic [4:0] CHAN_VREF_LO = 5'h1e;
  localparam logic [4:0] CHAN_OFF = 5'h1f;

  // ==========================================================================
  // Timing and reset values
  localparam int CONV_CYCLES = 16;
  localparam logic [3:0] CONV_LAST = 4'hf;
  localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [3:0] DIV_MAX_LIMIT = 4'hf;

  // Status and control register image
  typedef struct packed {
    logic complete_flag;
    logic ien;
    logic cont;
    logic [4:0] channel_field;
  } sac_sc_t;

  localparam sac_sc_t SC_RESET = '{complete_flag: 1'b0, ien: 1'b0, cont: 1'b0, channel_field: CHAN_OFF};

  // Port A view shared with the port logic
  typedef struct packed {
    logic [5:0] latch;
    logic [5:0] ddr;
    logic [5:0] pin;
  } sac_port_t;

  typedef enum logic {SAC_IDLE, SAC_CONV} sac_state_t;

  // Channel code to port A pin mask (pins 0, 1, 4, 5)
  function automatic logic [5:0] chan_mask(input logic [4:0] code);
    logic [5:0] m;
    m = 6'h00;
    unique case (code)
      5'h00: m = 6'h01;
      5'h01: m = 6'h02;
      5'h02: m = 6'h10;
      5'h03: m = 6'h20;
      default: m = 6'h00;
    endcase
    return m;
  endfunction

endpackage

// file: verilog/sac_prescaler.sv
// Converter clock prescaler: emits a one-cycle tick per divided clock period.
// Assumes restart is a synchronous pulse or level from the control logic.
`timescale 1ns/1ps
module sac_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic restart,
  input wire logic [2:0] div_sel,
  // Divided clock event
  output logic tick
);

  logic [3:0] count;
  logic [3:0] limit;
  logic [4:0] since_tick;

  // ==========================================================================
  // Divide ratio
  // divide ratio decode
  always_comb begin
    if (div_sel[2]) begin
      limit = sac_pkg::DIV_MAX_LIMIT;
    end else begin
      limit = 4'((5'h01 << div_sel[1:0]) - 5'h01);
    end
  end

  // Phase counter; restart realigns the divided clock to a register write
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      count <= 4'h0;
    end else if (count >= limit) begin
      count <= 4'h0;
    end else begin
      count <= count + 4'h1;
    end
  end

  assign tick = !restart && (count >= limit);

  // Cycles since the last tick or restart; a counter instead of a long repetition
  always_ff @(posedge clk) begin
    if (rst || restart || tick) begin
      since_tick <= 5'h00;
    end else if (since_tick != 5'h1f) begin
      since_tick <= since_tick + 5'h01;
    end
  end

  div16_spacing_a: assert property (@(posedge clk) disable iff (rst)
    div_sel[2] && !restart && since_tick == 5'h0f |-> tick)
    else $error("divide by sixteen tick missing");

endmodule // sac_prescaler

// file: verilog/sac_sar.sv
// Successive-approximation sequencer: two converter clocks per result bit.
// Assumes an external DAC and comparator; comp_high is 1 when input >= trial.
`timescale 1ns/1ps
module sac_sar (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sequencing
  input wire logic start,
  input wire logic step,
  input wire logic comp_high,
  // Outputs
  output logic [7:0] trial,
  output logic [3:0] phase,
  output logic done,
  output logic [7:0] result
);

  logic [2:0] bit_idx;
  logic [7:0] kept;

  // ==========================================================================
  // Bit decision
  // Odd phases judge the current bit, even phases let the DAC settle
  always_comb begin
    bit_idx = 3'd7 - phase[3:1];
    kept = comp_high ? trial : (trial & ~(8'h01 << bit_idx));
  end

  always_ff @(posedge clk) begin
    if (rst || start) begin
      phase <= 4'h0;
      trial <= sac_pkg::SAR_FIRST_TRIAL;
    end else if (step) begin
      phase <= phase + 4'h1;
      if (phase == sac_pkg::CONV_LAST) begin
        trial <= sac_pkg::SAR_FIRST_TRIAL;
      end else if (phase[0]) begin
        trial <= kept | (8'h80 >> (4'(phase[3:1]) + 4'h1));
      end
    end
  end

  assign done = step && (phase == sac_pkg::CONV_LAST);
  assign result = kept;

  // Trial reloads after the last phase
  reload_trial_a: assert property (@(posedge clk) disable iff (rst)
    done && !start |=> trial == sac_pkg::SAR_FIRST_TRIAL && phase == 4'h0)
    else $error("trial not reloaded after conversion");

endmodule // sac_sar
